// [shared/output_clock_synthesis_pkg.sv]
/*
 * Constants, tables and carrier types for the output clock synthesis block.
 * Assumes a 32-bit phase accumulator scaled to the 204.8 MHz master rate.
 */
package output_clock_synthesis_pkg;

    // ****************************************************************
    // Timing and scaling
    // ****************************************************************
    localparam int ACC_W = 32;
    localparam longint MASTER_HZ = 204800000;
    localparam longint CLK_HZ = 25000000;
    localparam longint CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    localparam longint FRAME_HZ = 8000;
    localparam longint APLL2_HZ = 312500000;
    localparam int FB_DIV_SHIFT = 2;
    localparam int PHASE_CODE_W = 3;

    // Increment for a given rate at the master clock
    function automatic logic [31:0] rateInc(input longint hz);
        rateInc = 32'((hz * 64'h100000000) / MASTER_HZ);
    endfunction : rateInc

    localparam logic [31:0] MAIN_NOM_INC = rateInc(77760000);
    localparam logic [31:0] AUX_NOM_INC = rateInc(2048000);
    localparam logic [31:0] FRAME_INC = rateInc(FRAME_HZ);

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_BANDWIDTH = 8'h00;
    localparam logic [7:0] ADDR_OUT_SEL = 8'h04;
    localparam logic [7:0] ADDR_MASTER_CONFIG_SIX = 8'h08;
    localparam logic [7:0] ADDR_MASTER_CONFIG_SEVEN = 8'h0C;
    localparam logic [7:0] ADDR_MASTER_CONFIG_EIGHT = 8'h10;
    localparam logic [7:0] ADDR_FRAME_SYNC_CONFIG_TWO = 8'h14;
    localparam logic [7:0] ADDR_SYNC_WIDTH = 8'h18;
    localparam logic [7:0] ADDR_APLL_SEL = 8'h1C;
    localparam logic [7:0] ADDR_AUX_APLL_INC = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam logic [2:0] BW_MAIN_MAX = 3'h6;
    localparam logic [2:0] BW_MAIN_RESET = 3'h0;
    localparam logic [1:0] BW_AUX_RESET = 2'h0;
    localparam logic [1:0] FMT_OFF = 2'h0;
    localparam logic [1:0] FMT_LVDS = 2'h1;
    localparam logic [1:0] FMT_LVPECL = 2'h2;
    localparam logic [2:0] SRC_MAIN = 3'h0;
    localparam logic [2:0] SRC_DIG_A = 3'h1;
    localparam logic [2:0] SRC_DIG_B = 3'h2;
    localparam logic [2:0] SRC_8K = 3'h3;
    localparam logic [2:0] SRC_2K = 3'h4;
    localparam logic [2:0] SRC_APLL_MAIN = 3'h5;
    localparam logic [2:0] SRC_APLL2 = 3'h6;
    localparam logic [2:0] SRC_APLL_AUX = 3'h7;
    localparam logic [7:0] WIDTH_RESET = 8'h01;
    localparam logic [1:0] MULTIFRAME_LAST = 2'h3;

    // ****************************************************************
    // Rate tables, digital ones indexed {standard, freq}, APLL main one by APLL select
    // ****************************************************************
    localparam logic [31:0] DIG_A_INC [8] = '{
        rateInc(2048000), rateInc(4096000), rateInc(8192000), rateInc(16384000),
        rateInc(1544000), rateInc(3088000), rateInc(6176000), rateInc(12352000)};
    localparam logic [31:0] DIG_B_ALT_INC [8] = '{
        rateInc(6312000), 32'h0, rateInc(10000000), 32'h0,
        rateInc(19440000), rateInc(38880000), 32'h0, 32'h0};
    localparam logic [31:0] APLL_MAIN_INC [8] = '{
        rateInc(77760000), rateInc(77760000), rateInc(24576000), rateInc(32768000),
        rateInc(37056000), 32'h0, 32'h0, 32'h0};

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [2:0] seSel;
        logic [2:0] diffSel;
        logic [1:0] diffFmt;
    } out_cfg_t;

    typedef struct packed {
        logic sync_independent_mode;
        logic fsPol;
        logic mfsPol;
        logic [7:0] fsWidth;
        logic [7:0] mfsWidth;
    } sync_cfg_t;

    typedef struct packed {
        logic digAStd;
        logic [1:0] digAFreq;
        logic digBAlt;
        logic digBStd;
        logic [1:0] digBFreq;
    } dig_cfg_t;

endpackage : output_clock_synthesis_pkg

// [rtl/output_clock_synthesis.sv]
/*
 * Output clock synthesis: phase-accumulator synthesizers for the main and
 * auxiliary paths, sync, low-rate, digital-rate and analog-PLL references.
 * Assumes frequency adjust words from the loops arrive on clk_sys, and that
 * clk_sys stands in for the master clock in all increment scaling.
 */
// Implementation choices: the register addresses and the address-and-strobe port.
module output_clock_synthesis
    import output_clock_synthesis_pkg::*;
#(
    parameter int NUM_SYN = 11
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [31:0] regRdData,
    input wire logic [15:0] mainFreqAdj,
    input wire logic [15:0] auxFreqAdj,
    input wire logic [31:0] mainPhaseOffset,
    output logic [2:0] mainBandwidthSel,
    output logic [1:0] auxBandwidthSel,
    output logic mainOutClk,
    output logic mainFeedbackClk,
    output logic auxOutClk,
    output logic auxFeedbackClk,
    output logic [2:0] apllRefClk,
    output logic single_ended_clock_out,
    output logic [2:0] seEdgePhase,
    output logic diffClockOutP,
    output logic diffClockOutN,
    output logic [1:0] diffFormat,
    output logic frame_sync_out,
    output logic multiframe_sync_out
);

    // ****************************************************************
    // Synthesizer indices
    // ****************************************************************
    localparam int S_MAIN = 0;
    localparam int S_AUX = 1;
    localparam int S_LOW = 2;
    localparam int S_DIGA = 3;
    localparam int S_DIGB = 4;
    localparam int S_APM = 5;
    localparam int S_AP2 = 6;
    localparam int S_APA = 7;
    localparam int S_SYNC = 8;
    localparam int S_MFB = 9;
    localparam int S_AFB = 10;
    localparam logic [31:0] APLL2_INC = rateInc(APLL2_HZ / 4);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [2:0] bwMain_q;
    logic [1:0] bwAux_q;
    out_cfg_t outCfg_q;
    dig_cfg_t digCfg_q;
    sync_cfg_t syncCfg_q;
    logic [2:0] apllSel_q;
    logic [31:0] auxApllInc_q;
    logic [31:0] rdData_d;
    logic [1:0] frameCnt_q;

    // Address decode
    wire wrBw = regWrEn && (regAddr == ADDR_BANDWIDTH);
    wire wrOut = regWrEn && (regAddr == ADDR_OUT_SEL);
    wire wrSix = regWrEn && (regAddr == ADDR_MASTER_CONFIG_SIX);
    wire wrSeven = regWrEn && (regAddr == ADDR_MASTER_CONFIG_SEVEN);
    wire wrEight = regWrEn && (regAddr == ADDR_MASTER_CONFIG_EIGHT);
    wire wrFsc = regWrEn && (regAddr == ADDR_FRAME_SYNC_CONFIG_TWO);
    wire wrWidth = regWrEn && (regAddr == ADDR_SYNC_WIDTH);
    wire wrApll = regWrEn && (regAddr == ADDR_APLL_SEL);
    wire wrAuxInc = regWrEn && (regAddr == ADDR_AUX_APLL_INC);
    // Main bandwidth clamps to the seventh setting
    wire [2:0] bwMainWr = (regWrData[2:0] > BW_MAIN_MAX) ? BW_MAIN_MAX : regWrData[2:0];

    // Register writes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bwMain_q <= BW_MAIN_RESET;
            bwAux_q <= BW_AUX_RESET;
            outCfg_q <= '{seSel: SRC_MAIN, diffSel: SRC_MAIN, diffFmt: FMT_OFF};
            digCfg_q <= '0;
            syncCfg_q <= '{sync_independent_mode: 1'b0, fsPol: 1'b0, mfsPol: 1'b0,
                           fsWidth: WIDTH_RESET, mfsWidth: WIDTH_RESET};
            apllSel_q <= 3'h0;
            auxApllInc_q <= 32'h0;
        end else begin
            if (wrBw) begin
                bwMain_q <= bwMainWr;
                bwAux_q <= regWrData[5:4];
            end
            if (wrOut) begin
                outCfg_q.seSel <= regWrData[2:0];
                outCfg_q.diffSel <= regWrData[6:4];
            end
            if (wrEight) begin
                outCfg_q.diffFmt <= regWrData[1:0];
            end
            if (wrSix) begin
                digCfg_q.digAStd <= regWrData[0];
                digCfg_q.digBStd <= regWrData[1];
                digCfg_q.digBAlt <= regWrData[2];
            end
            if (wrSeven) begin
                digCfg_q.digAFreq <= regWrData[1:0];
                digCfg_q.digBFreq <= regWrData[3:2];
            end
            if (wrFsc) begin
                syncCfg_q.sync_independent_mode <= regWrData[0];
                syncCfg_q.fsPol <= regWrData[1];
                syncCfg_q.mfsPol <= regWrData[2];
            end
            if (wrWidth) begin
                syncCfg_q.fsWidth <= regWrData[7:0];
                syncCfg_q.mfsWidth <= regWrData[15:8];
            end
            if (wrApll) begin
                apllSel_q <= regWrData[2:0];
            end
            if (wrAuxInc) begin
                auxApllInc_q <= regWrData;
            end
        end
    end

    // ****************************************************************
    // Increments
    // ****************************************************************
    logic [31:0] inc [NUM_SYN];
    logic [31:0] acc_q [NUM_SYN];
    logic [31:0] acc_d [NUM_SYN];
    wire [31:0] mainAdjExt = {{16{mainFreqAdj[15]}}, mainFreqAdj};
    wire [31:0] auxAdjExt = {{16{auxFreqAdj[15]}}, auxFreqAdj};
    wire [31:0] mainFwdInc = MAIN_NOM_INC + mainAdjExt;
    wire [31:0] auxFwdInc = AUX_NOM_INC + auxAdjExt;
    wire [2:0] digAIdx = {digCfg_q.digAStd, digCfg_q.digAFreq};
    wire [2:0] digBIdx = {digCfg_q.digBStd, digCfg_q.digBFreq};
    wire [31:0] digBNom = digCfg_q.digBAlt ? DIG_B_ALT_INC[digBIdx] : DIG_A_INC[digBIdx];

    // Output synthesizers other than the auxiliary one carry the main path frequency correction
    assign inc[S_MAIN] = mainFwdInc;
    assign inc[S_AUX] = auxFwdInc;
    assign inc[S_LOW] = FRAME_INC + mainAdjExt;
    assign inc[S_DIGA] = (DIG_A_INC[digAIdx] == 32'h0) ? 32'h0
                                                       : DIG_A_INC[digAIdx] + mainAdjExt;
    assign inc[S_DIGB] = (digBNom == 32'h0) ? 32'h0 : digBNom + mainAdjExt;
    assign inc[S_APM] = (APLL_MAIN_INC[apllSel_q] == 32'h0) ? 32'h0
                                                            : APLL_MAIN_INC[apllSel_q] + mainAdjExt;
    assign inc[S_AP2] = APLL2_INC + mainAdjExt;
    assign inc[S_APA] = (auxApllInc_q == 32'h0) ? 32'h0 : auxApllInc_q + mainAdjExt;
    assign inc[S_SYNC] = FRAME_INC + mainAdjExt;
    // Feedback synthesizers follow their own forward increment
    assign inc[S_MFB] = mainFwdInc >> FB_DIV_SHIFT;
    assign inc[S_AFB] = auxFwdInc >> FB_DIV_SHIFT;

    // ****************************************************************
    // Phase accumulators
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_SYN; g++) begin : gSyn
            // Sync accumulator tracks the low-rate one unless independent
            if (g == S_SYNC) begin : gSync
                assign acc_d[g] = syncCfg_q.sync_independent_mode ? acc_q[g] + inc[g] : acc_d[S_LOW];
            end else begin : gFree
                assign acc_d[g] = acc_q[g] + inc[g];
            end
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    acc_q[g] <= 32'h0;
                end else begin
                    acc_q[g] <= acc_d[g];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Derived clocks
    // ****************************************************************
    logic [1:0] lowDiv_q;
    logic lowMsb_q;
    logic syncMsb_q;
    wire [31:0] mainFbPhase = acc_q[S_MFB] + mainPhaseOffset;
    wire lowRise = acc_q[S_LOW][ACC_W-1] && !lowMsb_q;
    wire frameEdge = acc_q[S_SYNC][ACC_W-1] && !syncMsb_q;
    wire clk2k = lowDiv_q[1];

    // Source selection for the general outputs
    function automatic logic pickSrc(input logic [2:0] sel, input logic [7:0] srcs);
        pickSrc = srcs[sel];
    endfunction : pickSrc

    wire [7:0] srcBus = {acc_q[S_APA][ACC_W-1], acc_q[S_AP2][ACC_W-1],
                         acc_q[S_APM][ACC_W-1], clk2k, acc_q[S_LOW][ACC_W-1],
                         acc_q[S_DIGB][ACC_W-1], acc_q[S_DIGA][ACC_W-1],
                         acc_q[S_MAIN][ACC_W-1]};
    wire seNext = pickSrc(outCfg_q.seSel, srcBus);
    wire diffNext = pickSrc(outCfg_q.diffSel, srcBus);
    wire diffOn = (outCfg_q.diffFmt == FMT_LVDS) || (outCfg_q.diffFmt == FMT_LVPECL);
    // Main accumulator residue below the top bit is latched on each single-ended edge, whichever source is selected
    wire seEdge = seNext != single_ended_clock_out;
    wire [2:0] edgeCode = acc_q[S_MAIN][ACC_W-2 -: PHASE_CODE_W];

    // Low-rate divider and edge history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lowDiv_q <= 2'h0;
            lowMsb_q <= 1'b0;
            syncMsb_q <= 1'b0;
        end else begin
            lowMsb_q <= acc_q[S_LOW][ACC_W-1];
            syncMsb_q <= acc_q[S_SYNC][ACC_W-1];
            if (lowRise) begin
                lowDiv_q <= lowDiv_q + 2'h1;
            end
        end
    end

    // ****************************************************************
    // Frame and multiframe pulses
    // ****************************************************************
    logic [7:0] fsCnt_q;
    logic [7:0] mfsCnt_q;
    wire [7:0] fsLoad = (syncCfg_q.fsWidth == 8'h00) ? 8'h01 : syncCfg_q.fsWidth;
    wire [7:0] mfsLoad = (syncCfg_q.mfsWidth == 8'h00) ? 8'h01 : syncCfg_q.mfsWidth;
    wire mfEdge = frameEdge && (frameCnt_q == MULTIFRAME_LAST);

    // Frame width counter loads on each frame edge, multiframe one on every fourth frame edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fsCnt_q <= 8'h00;
            mfsCnt_q <= 8'h00;
            frameCnt_q <= 2'h0;
        end else begin
            if (frameEdge) begin
                frameCnt_q <= frameCnt_q + 2'h1;
            end
            if (frameEdge) begin
                fsCnt_q <= fsLoad;
            end else if (fsCnt_q != 8'h00) begin
                fsCnt_q <= fsCnt_q - 8'h01;
            end
            if (mfEdge) begin
                mfsCnt_q <= mfsLoad;
            end else if (mfsCnt_q != 8'h00) begin
                mfsCnt_q <= mfsCnt_q - 8'h01;
            end
        end
    end

    // ****************************************************************
    // Output registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mainOutClk <= 1'b0;
            mainFeedbackClk <= 1'b0;
            auxOutClk <= 1'b0;
            auxFeedbackClk <= 1'b0;
            apllRefClk <= 3'h0;
            single_ended_clock_out <= 1'b0;
            seEdgePhase <= 3'h0;
            diffClockOutP <= 1'b0;
            diffClockOutN <= 1'b1;
            diffFormat <= FMT_OFF;
            frame_sync_out <= 1'b0;
            multiframe_sync_out <= 1'b0;
            mainBandwidthSel <= BW_MAIN_RESET;
            auxBandwidthSel <= BW_AUX_RESET;
        end else begin
            mainOutClk <= acc_q[S_MAIN][ACC_W-1];
            mainFeedbackClk <= mainFbPhase[ACC_W-1];
            auxOutClk <= acc_q[S_AUX][ACC_W-1];
            auxFeedbackClk <= acc_q[S_AFB][ACC_W-1];
            apllRefClk <= {acc_q[S_APA][ACC_W-1], acc_q[S_AP2][ACC_W-1],
                           acc_q[S_APM][ACC_W-1]};
            single_ended_clock_out <= seNext;
            if (seEdge) begin
                seEdgePhase <= edgeCode;
            end
            diffClockOutP <= diffOn && diffNext;
            diffClockOutN <= !(diffOn && diffNext);
            diffFormat <= diffOn ? outCfg_q.diffFmt : FMT_OFF;
            frame_sync_out <= (fsCnt_q != 8'h00) ^ syncCfg_q.fsPol;
            multiframe_sync_out <= (mfsCnt_q != 8'h00) ^ syncCfg_q.mfsPol;
            mainBandwidthSel <= bwMain_q;
            auxBandwidthSel <= bwAux_q;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        rdData_d = 32'h0;
        case (regAddr)
            ADDR_BANDWIDTH: rdData_d = {26'h0, bwAux_q, 1'b0, bwMain_q};
            ADDR_OUT_SEL: rdData_d = {25'h0, outCfg_q.diffSel, 1'b0, outCfg_q.seSel};
            ADDR_MASTER_CONFIG_SIX: rdData_d = {29'h0, digCfg_q.digBAlt,
                                                digCfg_q.digBStd, digCfg_q.digAStd};
            ADDR_MASTER_CONFIG_SEVEN: rdData_d = {28'h0, digCfg_q.digBFreq, digCfg_q.digAFreq};
            ADDR_MASTER_CONFIG_EIGHT: rdData_d = {30'h0, outCfg_q.diffFmt};
            ADDR_FRAME_SYNC_CONFIG_TWO: rdData_d = {29'h0, syncCfg_q.mfsPol,
                                                    syncCfg_q.fsPol, syncCfg_q.sync_independent_mode};
            ADDR_SYNC_WIDTH: rdData_d = {16'h0, syncCfg_q.mfsWidth, syncCfg_q.fsWidth};
            ADDR_APLL_SEL: rdData_d = {29'h0, apllSel_q};
            ADDR_AUX_APLL_INC: rdData_d = auxApllInc_q;
            ADDR_STATUS: rdData_d = {26'h0, frameCnt_q, multiframe_sync_out,
                                     frame_sync_out, diffOn, single_ended_clock_out};
            default: rdData_d = 32'h0;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 32'h0;
        end else begin
            regRdData <= regRdEn ? rdData_d : 32'h0;
        end
    end

endmodule : output_clock_synthesis

// [verification/output_clock_synthesis_monitor.sv]
/* Port checker for the output clock synthesis block.
   Assumes a bind to the top module and a single clock domain. */
module output_clock_synthesis_monitor
    import output_clock_synthesis_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [31:0] regRdData,
    input wire logic [2:0] mainBandwidthSel,
    input wire logic [1:0] auxBandwidthSel,
    input wire logic [1:0] diffFormat,
    input wire logic diffClockOutP,
    input wire logic diffClockOutN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Bandwidth fields reach the pins two edges after the write, the main one clamped and then held
    chk_main_bw_clamp: assert property (regWrEn && regAddr == ADDR_BANDWIDTH |-> ##2
        mainBandwidthSel == ($past(regWrData[2:0], 2) == 3'h7 ? BW_MAIN_MAX
                                                            : $past(regWrData[2:0], 2)))
        else $error("main bandwidth not loaded or clamped");
    chk_main_bw_hold: assert property ($changed(mainBandwidthSel) |->
        $past(regWrEn, 2) && $past(regAddr, 2) == ADDR_BANDWIDTH)
        else $error("main bandwidth drifted");
    chk_aux_bw_load: assert property (regWrEn && regAddr == ADDR_BANDWIDTH |-> ##2
        auxBandwidthSel == $past(regWrData[5:4], 2)) else $error("aux bandwidth not loaded");
    // Differential format and pin pair
    chk_fmt_legal: assert property (diffFormat != 2'h3)
        else $error("diff format shows unused code");
    chk_fmt_cause: assert property ($changed(diffFormat) |->
        $past(regWrEn, 2) && $past(regAddr, 2) == ADDR_MASTER_CONFIG_EIGHT)
        else $error("diff format changed without write");
    chk_diff_static: assert property (diffFormat == FMT_OFF |->
        !diffClockOutP && diffClockOutN) else $error("disabled diff output not static");
    chk_diff_pair: assert property (diffFormat != FMT_OFF |->
        diffClockOutP != diffClockOutN) else $error("diff pins not complementary");
    // Read data stands only after a read strobe
    chk_rd_idle: assert property (!regRdEn |=> regRdData == 32'h0)
        else $error("read data outside read slot");
endmodule : output_clock_synthesis_monitor

bind output_clock_synthesis output_clock_synthesis_monitor output_clock_synthesis_monitor_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .mainBandwidthSel(mainBandwidthSel), .auxBandwidthSel(auxBandwidthSel),
    .diffFormat(diffFormat), .diffClockOutP(diffClockOutP), .diffClockOutN(diffClockOutN));

// [verification/clock_receiver_model.sv]
/* Downstream receiver: counts rising edges of one clock or sync line,
   keeps the last high time and rise spacing. Assumes sampling on clk_sys. */
module clock_receiver_model (
    input wire logic clk_sys,
    input wire logic sigIn,
    output int riseCnt,
    output int highLen,
    output int period
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lastQ = 1'b0;
    int runLen = 0;
    int sinceRise = 0;
    initial begin
        riseCnt = 0;
        highLen = 0;
        period = 0;
    end
    // Edge counting and pulse measurement
    always @(posedge clk_sys) begin
        runLen <= sigIn ? runLen + 1 : 0;
        sinceRise <= sinceRise + 1;
        if (!sigIn && lastQ) highLen <= runLen;
        if (sigIn && !lastQ) begin
            riseCnt <= riseCnt + 1;
            period <= sinceRise;
            sinceRise <= 1;
        end
        lastQ <= sigIn;
    end
endmodule : clock_receiver_model

// [verification/output_clock_synthesis_bench.sv]
/* Self-checking bench for the output clock synthesis block.
   Assumes the monitor is bound and receiver models watch the single-ended and frame sync outputs. */
module output_clock_synthesis_bench
    import output_clock_synthesis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, mainPhaseOffset = 32'h0, regRdData, rd, v;
    logic [15:0] mainFreqAdj = 16'h0, auxFreqAdj = 16'h0;
    logic [2:0] mainBandwidthSel, apllRefClk, seEdgePhase;
    logic [1:0] auxBandwidthSel, diffFormat;
    logic mainOutClk, mainFeedbackClk, auxOutClk, auxFeedbackClk, seOut, diffP, diffN, fsOut, mfOut;
    int err_total = 0, checked = 0, seRise, seHigh, sePer, fsRise, fsHigh, fsPer;
    output_clock_synthesis output_clock_synthesis_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .mainFreqAdj(mainFreqAdj), .auxFreqAdj(auxFreqAdj),
        .mainPhaseOffset(mainPhaseOffset), .mainBandwidthSel(mainBandwidthSel),
        .auxBandwidthSel(auxBandwidthSel), .mainOutClk(mainOutClk), .mainFeedbackClk(mainFeedbackClk),
        .auxOutClk(auxOutClk), .auxFeedbackClk(auxFeedbackClk), .apllRefClk(apllRefClk),
        .single_ended_clock_out(seOut), .seEdgePhase(seEdgePhase), .diffClockOutP(diffP),
        .diffClockOutN(diffN), .diffFormat(diffFormat), .frame_sync_out(fsOut),
        .multiframe_sync_out(mfOut));
    clock_receiver_model seReceiver (.clk_sys(clk_sys), .sigIn(seOut), .riseCnt(seRise),
        .highLen(seHigh), .period(sePer));
    clock_receiver_model frameReceiver (.clk_sys(clk_sys), .sigIn(fsOut), .riseCnt(fsRise),
        .highLen(fsHigh), .period(fsPer));
    // Clock at 40 ns
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One register write or read, result lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= w;
        regRdEn <= !w;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regRdEn <= 1'b0;
        #1 rd = regRdData;
    endtask : bus
    // Expected digital-rate frequency in Hz
    function automatic real digHz(input logic alt, input logic std, input logic [1:0] f);
        if (!alt) return (std ? 1544000.0 : 2048000.0) * (1 << f);
        case ({std, f})
            3'b000: return 6312000.0;
            3'b010: return 1.0e7;
            3'b100: return 1.944e7;
            3'b101: return 3.888e7;
            default: return 0.0;
        endcase
    endfunction : digHz
    // Route a source to the single-ended pin and count its edges
    task automatic rate(input logic [2:0] src, input real hz, input int n);
        int c0;
        real d;
        bus(1'b1, ADDR_OUT_SEL, {25'h0, 3'h1, 1'b0, src});
        repeat (3) @(posedge clk_sys);
        c0 = seRise;
        repeat (n) @(posedge clk_sys);
        d = (seRise - c0) - n * hz / 204.8e6;
        check("rise count", d <= 1.0 && d >= -1.0, 1);
    endtask : rate
    // Verdict
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        err_total++;
        test_done;
    end
    // Main sequence
    initial begin
        void'($urandom(29));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            if (i < 2) v[2:0] = 3'h6 + 3'(i);
            bus(1'b1, ADDR_BANDWIDTH, v);
            @(posedge clk_sys);
            #1 check("mainBw", mainBandwidthSel, v[2:0] == 3'h7 ? 3'h6 : v[2:0]);
            check("auxBw", auxBandwidthSel, v[5:4]);
        end
        v = $urandom & 32'h5;
        bus(1'b1, ADDR_FRAME_SYNC_CONFIG_TWO, v);
        bus(1'b0, ADDR_FRAME_SYNC_CONFIG_TWO, 32'h0);
        check("syncCfg", rd, v);
        bus(1'b0, 8'h30, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, ADDR_FRAME_SYNC_CONFIG_TWO, 32'h0);
        bus(1'b1, ADDR_SYNC_WIDTH, 32'h0905);
        bus(1'b0, ADDR_SYNC_WIDTH, 32'h0);
        check("syncWidth", rd, 32'h0905);
        for (int f = 0; f < 5; f++) begin
            bus(1'b1, ADDR_MASTER_CONFIG_EIGHT, f % 4);
            @(posedge clk_sys);
            #1 check("diffFmt", diffFormat, f % 4 == 3 ? 0 : f % 4);
        end
        check("diffOff", {diffP, diffN}, 2'b01);
        @(posedge clk_sys);
        mainPhaseOffset <= $urandom;
        auxFreqAdj <= 16'($urandom);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, ADDR_MASTER_CONFIG_SIX, {31'h0, i[2]});
            bus(1'b1, ADDR_MASTER_CONFIG_SEVEN, {30'h0, i[1:0]});
            rate(SRC_DIG_A, digHz(1'b0, i[2], i[1:0]), 2048);
        end
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, ADDR_MASTER_CONFIG_SIX, {29'h0, i[3], i[2], 1'b0});
            bus(1'b1, ADDR_MASTER_CONFIG_SEVEN, {28'h0, i[1:0], 2'h3});
            rate(SRC_DIG_B, digHz(i[3], i[2], i[1:0]), 1024);
        end
        rate(SRC_DIG_A, digHz(1'b0, 1'b0, 2'h3), 1024);
        rate(SRC_APLL2, 7.8125e7, 1024);
        rate(SRC_MAIN, 7.776e7, 1024);
        for (int k = 0; k < 60000 && fsRise < 2; k++) @(posedge clk_sys);
        check("fsWidth", fsHigh, 5);
        check("fsPeriod", fsPer == 25600 || fsPer == 25601, 1);
        // Only two frames so far, so the multiframe line is idle and shows polarity
        check("mfIdle", mfOut, 1'b0);
        bus(1'b1, ADDR_FRAME_SYNC_CONFIG_TWO, 32'h4);
        @(posedge clk_sys);
        #1 check("mfIdlePol", mfOut, 1'b1);
        test_done;
    end
endmodule : output_clock_synthesis_bench
